// file: hdl/overcurrent_pkg.sv
// Package with constants, record layout and types of the overcurrent stage.
// Operation
// - Sample blocking input once per program cycle.
// - Pick-up without blocking raises START, starts timing.
// - Pick-up while blocked raises BLOCKED only.
// - Late blocking drops START, runs release timing.
// - Inrush blocking enable, off after reset.
// - Harmonic limit in 0.01 percent, default 0.01.
// - Fixed and inverse delay curves selectable.
// - ON/OFF events for stage and each phase.
// - Per-event ON/OFF selection for event output.
// - Every stored event carries its time stamp.
// - Clearable START, TRIP and BLOCKED counters.
// - Twelve-deep circular record buffer, oldest overwritten.
// - Records written on ON edges only.
// - Record holds stamp, event, phases, three currents.
// - Record holds remaining trip time, setting group.
// - START, TRIP, BLOCKED outputs routed out.
// - Pick-up above threshold, release below 97 percent.
package overcurrent_pkg;
  localparam int CLK_HZ = 32'hEE6B280;
  localparam int CYCLE_TIME_US = 32'h3E8;
  localparam int CYCLE_CLKS = CLK_HZ / 32'hF4240 * CYCLE_TIME_US;
  localparam int BLOCK_LEAD_MS = 32'h5;
  localparam logic [22:0] PCT_FULL = 23'h64;
  localparam logic [22:0] RELEASE_PCT = 23'h61;
  localparam logic [29:0] HARM_SCALE = 30'h2710;
  localparam logic [3:0] REC_DEPTH = 4'hC;
  localparam int PRE_TRIG_MS = 32'h14;
  localparam int PRE_FAULT_MS = 32'hC8;
  localparam int HIST_DEPTH = 32'h14;
  localparam int PRE_TRIG_STEP = PRE_TRIG_MS / HIST_DEPTH;
  localparam int PRE_FAULT_STEP = PRE_FAULT_MS / HIST_DEPTH;
  localparam logic [20:0] MAX_REMAIN_MS = 21'h1B7740;
  localparam int EVT_COUNT = 32'h9;
  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PICKUP = 8'h04;
  localparam logic [7:0] OFF_HARM = 8'h08;
  localparam logic [7:0] OFF_OPDLY = 8'h0C;
  localparam logic [7:0] OFF_RELDLY = 8'h10;
  localparam logic [7:0] OFF_EVMASK = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_CNT_START = 8'h1C;
  localparam logic [7:0] OFF_CNT_TRIP = 8'h20;
  localparam logic [7:0] OFF_CNT_BLOCK = 8'h24;
  localparam logic [7:0] OFF_REC_SEL = 8'h28;
  localparam logic [7:0] OFF_REC_STAMP = 8'h2C;
  localparam logic [7:0] OFF_REC_INFO = 8'h30;
  localparam logic [7:0] OFF_REC_CUR = 8'h34;
  localparam logic [7:0] OFF_REC_PRE = 8'h38;
  localparam logic [7:0] OFF_TIME = 8'h3C;
  // Field positions.
  localparam int CTRL_INRUSH_BIT = 0;
  localparam int CTRL_CURVE_BIT = 1;
  localparam int CTRL_CLR_LSB = 2;
  localparam int EVMASK_OFF_LSB = 16;
  // Reset values.
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [15:0] PICKUP_RST = 16'h00F0;
  localparam logic [12:0] HARM_RST = 13'h0001;
  localparam logic [20:0] OPDLY_RST = 21'h000064;
  localparam logic [20:0] RELDLY_RST = 21'h000000;
  localparam logic [8:0] EVMASK_RST = 9'h1FF;
  // Event indices: stage start, trip, block, phase starts, phase trips.
  localparam logic [3:0] EV_START = 4'h0;
  localparam logic [3:0] EV_TRIP = 4'h1;
  localparam logic [3:0] EV_BLOCK = 4'h2;
  localparam int EV_PH_START = 3;
  localparam int EV_PH_TRIP = 6;

  typedef logic [2:0][15:0] phase_current_type;

  typedef enum logic [1:0] {
    REC_NONE, REC_START, REC_TRIP, REC_BLOCK
  } rec_event_type;

  typedef struct packed {
    logic [31:0] stamp;
    rec_event_type event_kind;
    logic [2:0] fault_phases;
    logic [15:0] pre_trigger;
    logic [15:0] fault_cur;
    logic [15:0] pre_fault;
    logic [20:0] remain_ms;
    logic [3:0] group;
  } record_type;

  typedef struct packed {
    logic valid;
    logic [3:0] id;
    logic on;
    logic [31:0] stamp;
  } event_type;
endpackage : overcurrent_pkg

// file: hdl/sample_history.sv
// Delay line of current samples giving the sample DEPTH*STEP cycles old.
`timescale 1ns/1ps
module sample_history #(
  parameter int DEPTH = 20,
  parameter int STEP = 1
) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic tick_in,
  input wire logic [15:0] sample_in,
  output logic [15:0] oldest_out
);
  import overcurrent_pkg::*;
  logic [15:0] line_q [DEPTH];
  logic [7:0] step_q;
  wire step_end = step_q == 8'(STEP - 1);

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      step_q <= 8'h00;
    end else if (tick_in) begin
      step_q <= step_end ? 8'h00 : step_q + 8'h01;
    end
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_line
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        line_q[i] <= 16'h0000;
      end else if (tick_in && step_end) begin
        line_q[i] <= (i == 0) ? sample_in : line_q[(i == 0) ? 0 : i - 1];
      end
    end
  end

  assign oldest_out = line_q[DEPTH - 1];
endmodule : sample_history

// file: hdl/fault_record_buffer.sv
// Twelve-entry circular store of fault records, read newest first.
`timescale 1ns/1ps
module fault_record_buffer (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic write_in,
  input overcurrent_pkg::record_type record_in,
  input wire logic [3:0] sel_in,
  output overcurrent_pkg::record_type record_out,
  output logic [3:0] count_out
);
  import overcurrent_pkg::*;
  record_type store_q [REC_DEPTH];
  logic [3:0] wr_q;
  logic [3:0] count_q;
  logic [4:0] back;
  logic [4:0] idx;

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_q <= 4'h0;
      count_q <= 4'h0;
    end else if (write_in) begin
      wr_q <= (wr_q == REC_DEPTH - 4'h1) ? 4'h0 : wr_q + 4'h1;
      count_q <= (count_q == REC_DEPTH) ? count_q : count_q + 4'h1;
    end
  end

  for (genvar i = 0; i < REC_DEPTH; i++) begin : g_entry
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        store_q[i] <= '0;
      end else if (write_in && wr_q == 4'(i)) begin
        store_q[i] <= record_in;
      end
    end
  end

  // Selection 0 is the newest record; anything past the count reads zero.
  // Only selections below the count are used, so the sum stays below 23.
  assign back = {1'b0, wr_q} + {1'b0, REC_DEPTH} - 5'h01 - {1'b0, sel_in};
  assign idx = (back >= {1'b0, REC_DEPTH}) ? back - {1'b0, REC_DEPTH} : back;
  assign record_out = (sel_in < count_q) ? store_q[idx[3:0]] : '0;
  assign count_out = count_q;
endmodule : fault_record_buffer

// file: hdl/phase_overcurrent_stage.sv
// Phase overcurrent stage: blocking, start/trip timing, events and records.
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module phase_overcurrent_stage #(
  parameter int CYCLE_CLKS_P = overcurrent_pkg::CYCLE_CLKS
) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input overcurrent_pkg::phase_current_type current_in,
  input wire logic [15:0] harm2_in,
  input wire logic [15:0] fund_in,
  input wire logic [2:0] setting_group_in,
  input wire logic ext_block_in,
  output logic start_out,
  output logic trip_out,
  output logic blocked_out,
  output logic [2:0] phase_start_out,
  output logic [2:0] phase_trip_out,
  output overcurrent_pkg::event_type event_out
);
  import overcurrent_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_STARTED, ST_TRIPPED, ST_BLOCKED}
    stage_state_type;

  logic [1:0] ctrl_q;
  logic [15:0] pickup_q;
  logic [12:0] harm_q;
  logic [20:0] op_delay_q;
  logic [20:0] rel_delay_q;
  logic [8:0] on_mask_q;
  logic [8:0] off_mask_q;
  logic [3:0] rec_sel_q;
  logic [31:0] tick_cnt_q;
  logic tick_q;
  logic [31:0] time_q;
  logic blk_meta_q;
  logic blk_sync_q;
  logic blk_q;
  logic [2:0] pick_q;
  stage_state_type state_q;
  stage_state_type state_d;
  logic [20:0] op_cnt_q;
  logic [20:0] rel_cnt_q;
  logic [8:0] status_q;
  logic [8:0] status_d;
  logic [8:0] pend_on_q;
  logic [8:0] pend_off_q;
  logic [31:0] evt_stamp_q;
  logic [2:0][15:0] cnt_q;
  logic [2:0] clr_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  event_type event_q;
  record_type rec_new;
  record_type rec_rd;
  logic [3:0] rec_count;
  logic [15:0] pre_trig;
  logic [15:0] pre_fault;

  // Program cycle tick and millisecond time base.
  wire tick_last = tick_cnt_q == 32'(CYCLE_CLKS_P - 1);
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tick_cnt_q <= 32'h0;
      tick_q <= 1'b0;
      time_q <= 32'h0;
    end else begin
      tick_q <= tick_last;
      tick_cnt_q <= tick_last ? 32'h0 : tick_cnt_q + 32'h1;
      time_q <= tick_q ? time_q + 32'h1 : time_q;
    end
  end

  // Pick-up with built-in release ratio, per phase.
  wire [2:0] pick_d;
  for (genvar p = 0; p < 3; p++) begin : g_pick
    wire over = current_in[p] > pickup_q;
    wire hold = 23'(current_in[p]) * PCT_FULL >= 23'(pickup_q) * RELEASE_PCT;
    assign pick_d[p] = over | (pick_q[p] & hold);
  end
  wire pick_any = |pick_d;

  wire [15:0] imax_ab = (current_in[0] > current_in[1]) ? current_in[0] :
                        current_in[1];
  wire [15:0] imax = (imax_ab > current_in[2]) ? imax_ab : current_in[2];

  // Second-harmonic ratio against the limit in hundredths of a percent.
  wire inrush = ctrl_q[CTRL_INRUSH_BIT] &
    (30'(harm2_in) * HARM_SCALE > 30'(harm_q) * 30'(fund_in));
  wire blk_now = blk_q | inrush;

  // Delay of the selected curve in program cycles.
  wire [15:0] excess = (imax > pickup_q) ? imax - pickup_q : 16'h0000;
  wire [36:0] inverse_delay_curve_num = 37'(op_delay_q) * 37'(pickup_q);
  wire [36:0] inverse_delay_curve_raw = (excess == 16'h0000) ? 37'(op_delay_q) :
                         inverse_delay_curve_num / 37'(excess);
  wire [20:0] inverse_delay_curve_dly = (inverse_delay_curve_raw > 37'(MAX_REMAIN_MS)) ? MAX_REMAIN_MS :
                         inverse_delay_curve_raw[20:0];
  wire [20:0] delay_eff = ctrl_q[CTRL_CURVE_BIT] ? inverse_delay_curve_dly :
                          op_delay_q;
  wire op_done = op_cnt_q + 21'h1 >= delay_eff;
  wire rel_done = rel_cnt_q + 21'h1 >= rel_delay_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (pick_any) begin
          state_d = blk_now ? ST_BLOCKED : ST_STARTED;
        end
      end
      ST_STARTED: begin
        if (!pick_any || blk_now) begin
          state_d = ST_IDLE;
        end else if (op_done) begin
          state_d = ST_TRIPPED;
        end
      end
      ST_TRIPPED: begin
        if (!pick_any || blk_now) begin
          state_d = ST_IDLE;
        end
      end
      ST_BLOCKED: begin
        if (!pick_any) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  wire start_d = state_d == ST_STARTED || state_d == ST_TRIPPED;
  wire trip_d = state_d == ST_TRIPPED;
  assign status_d = {pick_d & {3{trip_d}}, pick_d & {3{start_d}},
                     state_d == ST_BLOCKED, trip_d, start_d};
  wire [8:0] rise = status_d & ~status_q;
  wire [8:0] fall = ~status_d & status_q;

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      blk_meta_q <= 1'b0;
      blk_sync_q <= 1'b0;
      blk_q <= 1'b0;
    end else begin
      blk_meta_q <= ext_block_in;
      blk_sync_q <= blk_meta_q;
      blk_q <= tick_q ? blk_sync_q : blk_q;
    end
  end

  // Stage timing: operate count while started, release count while idle or blocked after a start; both held when tripped.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= ST_IDLE;
      pick_q <= 3'h0;
      status_q <= 9'h0;
      op_cnt_q <= 21'h0;
      rel_cnt_q <= 21'h0;
      evt_stamp_q <= 32'h0;
    end else if (tick_q) begin
      state_q <= state_d;
      pick_q <= pick_d;
      status_q <= status_d;
      evt_stamp_q <= time_q;
      if (state_q == ST_STARTED) begin
        op_cnt_q <= op_cnt_q + 21'h1;
        rel_cnt_q <= 21'h0;
      end else if (state_q != ST_TRIPPED && op_cnt_q != 21'h0) begin
        rel_cnt_q <= rel_done ? 21'h0 : rel_cnt_q + 21'h1;
        op_cnt_q <= rel_done ? 21'h0 : op_cnt_q;
      end
    end
  end

  assign start_out = status_q[EV_START];
  assign trip_out = status_q[EV_TRIP];
  assign blocked_out = status_q[EV_BLOCK];
  assign phase_start_out = status_q[EV_PH_START +: 3];
  assign phase_trip_out = status_q[EV_PH_TRIP +: 3];

  // Event queue: one selected edge leaves per clock, ON edges before OFF edges, lowest index first.
  wire [8:0] grant_on = pend_on_q & -pend_on_q;
  wire [8:0] grant_off = (|pend_on_q) ? 9'h0 : pend_off_q & -pend_off_q;
  wire [8:0] grant = grant_on | grant_off;
  wire [8:0] new_on = tick_q ? rise & on_mask_q : 9'h0;
  wire [8:0] new_off = tick_q ? fall & off_mask_q : 9'h0;
  logic [3:0] grant_id;
  always_comb begin
    grant_id = 4'h0;
    for (int i = 0; i < EVT_COUNT; i++) begin
      if (grant[i]) begin
        grant_id = 4'(i);
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pend_on_q <= 9'h0;
      pend_off_q <= 9'h0;
      event_q <= '0;
    end else begin
      pend_on_q <= (pend_on_q & ~grant_on) | new_on;
      pend_off_q <= (pend_off_q & ~grant_off) | new_off;
      event_q <= '{valid: |grant, id: grant_id, on: |grant_on,
                   stamp: evt_stamp_q};
    end
  end
  assign event_out = event_q;

  // Cumulative counters; an increment in the clearing cycle still counts.
  wire [2:0] inc = tick_q ? rise[2:0] : 3'h0;
  for (genvar c = 0; c < 3; c++) begin : g_cnt
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        cnt_q[c] <= 16'h0;
      end else if (inc[c]) begin
        cnt_q[c] <= clr_q[c] ? 16'h1 : cnt_q[c] + 16'h1;
      end else if (clr_q[c]) begin
        cnt_q[c] <= 16'h0;
      end
    end
  end

  // Fault records on ON edges of trip, block or start.
  wire rec_we = tick_q & |rise[2:0];
  wire [20:0] remain = (delay_eff > op_cnt_q) ? delay_eff - op_cnt_q : 21'h0;
  assign rec_new = '{
    stamp: time_q,
    event_kind: rise[EV_TRIP] ? REC_TRIP :
                rise[EV_BLOCK] ? REC_BLOCK : REC_START,
    fault_phases: pick_d,
    pre_trigger: pre_trig,
    fault_cur: imax,
    pre_fault: pre_fault,
    remain_ms: trip_d ? 21'h0 : remain,
    group: {1'b0, setting_group_in} + 4'h1
  };

  sample_history #(.DEPTH(HIST_DEPTH), .STEP(PRE_TRIG_STEP)) u_hist_trig (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .tick_in(tick_q),
    .sample_in(imax),
    .oldest_out(pre_trig)
  );

  sample_history #(.DEPTH(HIST_DEPTH), .STEP(PRE_FAULT_STEP)) u_hist_pre (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .tick_in(tick_q),
    .sample_in(imax),
    .oldest_out(pre_fault)
  );

  fault_record_buffer u_records (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .write_in(rec_we),
    .record_in(rec_new),
    .sel_in(rec_sel_q),
    .record_out(rec_rd),
    .count_out(rec_count)
  );

  // APB slave: answer registered in setup, pready high in the access cycle.
  wire setup = psel_in & ~penable_in;
  wire wr_en = psel_in & penable_in & pwrite_in & pready_q;
  wire wr_ctrl = wr_en && paddr_in == OFF_CTRL;
  logic [31:0] rd_mux;
  logic rd_err;
  always_comb begin
    rd_err = 1'b0;
    case (paddr_in)
      OFF_CTRL: rd_mux = {30'h0, ctrl_q};
      OFF_PICKUP: rd_mux = {16'h0, pickup_q};
      OFF_HARM: rd_mux = {19'h0, harm_q};
      OFF_OPDLY: rd_mux = {11'h0, op_delay_q};
      OFF_RELDLY: rd_mux = {11'h0, rel_delay_q};
      OFF_EVMASK: rd_mux = {7'h0, off_mask_q, 7'h0, on_mask_q};
      OFF_STATUS: rd_mux = {19'h0, rec_count, status_q};
      OFF_CNT_START: rd_mux = {16'h0, cnt_q[0]};
      OFF_CNT_TRIP: rd_mux = {16'h0, cnt_q[1]};
      OFF_CNT_BLOCK: rd_mux = {16'h0, cnt_q[2]};
      OFF_REC_SEL: rd_mux = {28'h0, rec_sel_q};
      OFF_REC_STAMP: rd_mux = rec_rd.stamp;
      OFF_REC_INFO: rd_mux = {rec_rd.group, rec_rd.fault_phases,
                              rec_rd.event_kind, 2'h0, rec_rd.remain_ms};
      OFF_REC_CUR: rd_mux = {rec_rd.fault_cur, rec_rd.pre_trigger};
      OFF_REC_PRE: rd_mux = {16'h0, rec_rd.pre_fault};
      OFF_TIME: rd_mux = time_q;
      default: begin
        rd_mux = 32'h0;
        rd_err = 1'b1;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & rd_err;
      prdata_q <= (setup && !pwrite_in && !rd_err) ? rd_mux : 32'h0;
    end
  end
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign prdata_out = prdata_q;

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_q <= CTRL_RST;
      pickup_q <= PICKUP_RST;
      harm_q <= HARM_RST;
      op_delay_q <= OPDLY_RST;
      rel_delay_q <= RELDLY_RST;
      on_mask_q <= EVMASK_RST;
      off_mask_q <= EVMASK_RST;
      rec_sel_q <= 4'h0;
      clr_q <= 3'h0;
    end else begin
      clr_q <= wr_ctrl ? pwdata_in[CTRL_CLR_LSB +: 3] : 3'h0;
      if (wr_ctrl) begin
        ctrl_q <= pwdata_in[1:0];
      end
      if (wr_en && paddr_in == OFF_PICKUP) begin
        pickup_q <= pwdata_in[15:0];
      end
      if (wr_en && paddr_in == OFF_HARM) begin
        harm_q <= pwdata_in[12:0];
      end
      if (wr_en && paddr_in == OFF_OPDLY) begin
        op_delay_q <= pwdata_in[20:0];
      end
      if (wr_en && paddr_in == OFF_RELDLY) begin
        rel_delay_q <= pwdata_in[20:0];
      end
      if (wr_en && paddr_in == OFF_EVMASK) begin
        on_mask_q <= pwdata_in[8:0];
        off_mask_q <= pwdata_in[EVMASK_OFF_LSB +: 9];
      end
      if (wr_en && paddr_in == OFF_REC_SEL) begin
        rec_sel_q <= pwdata_in[3:0];
      end
    end
  end
endmodule : phase_overcurrent_stage

// file: verification/stage_source.sv
// Model of the current measurement and blocking matrix feeding the stage.
`timescale 1ns/1ps
module stage_source (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic [15:0] level_in,
  input wire logic [2:0] phase_in,
  input wire logic block_in,
  input wire logic [15:0] harm_in,
  output overcurrent_pkg::phase_current_type current_out,
  output logic [15:0] harm2_out,
  output logic [15:0] fund_out,
  output logic [2:0] group_out,
  output logic ext_block_out
);
  import overcurrent_pkg::*;
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      current_out <= '0;
      harm2_out <= 16'h0000;
      fund_out <= 16'h0000;
      group_out <= 3'h0;
      ext_block_out <= 1'b0;
    end else begin
      for (int p = 0; p < 3; p++)
        current_out[p] <= phase_in[p] ? level_in : 16'h0000;
      harm2_out <= harm_in;
      fund_out <= 16'h03E8;
      group_out <= 3'h2;
      // Blocking follows block_in one clock later, whatever the operate delay.
      ext_block_out <= block_in;
    end
  end
endmodule : stage_source

// file: verification/stage_chk.sv
// Checker of the stage's bus answer, output levels and event stream.
`timescale 1ns/1ps
module stage_chk #(
  parameter int CYCLE_CLKS_P = 20
) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic ext_block_in,
  input wire logic start_out,
  input wire logic trip_out,
  input wire logic blocked_out,
  input wire logic [2:0] phase_start_out,
  input overcurrent_pkg::event_type event_out
);
  import overcurrent_pkg::*;
  logic [15:0] blk_cnt_q;
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in)
      blk_cnt_q <= 16'h0000;
    else if (!ext_block_in)
      blk_cnt_q <= 16'h0000;
    else if (blk_cnt_q != 16'hFFFF)
      blk_cnt_q <= blk_cnt_q + 16'h0001;
  end
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  chk_ready_after_setup: assert property (
    psel_in && !penable_in |=> pready_out ##1 !pready_out)
    else $error("pready not a single cycle after setup");
  chk_err_with_ready: assert property (
    pslverr_out |-> pready_out) else $error("pslverr without pready");
  chk_start_blk_excl: assert property (
    !(start_out && blocked_out)) else $error("start and blocked together");
  chk_block_holds_off: assert property (
    blk_cnt_q > 3 * CYCLE_CLKS_P |-> !$rose(start_out))
    else $error("start rose under steady blocking");
  chk_trip_after_start: assert property (
    $rose(trip_out) |-> $past(start_out)) else $error("trip without start");
  chk_start_has_phase: assert property (
    $rose(start_out) |-> |phase_start_out) else $error("start no phase");
  chk_start_on_event: assert property (
    $rose(start_out) |-> ##[1:12] (event_out.valid &&
      event_out.id == EV_START && event_out.on))
    else $error("start on event missing");
  chk_start_off_event: assert property (
    $fell(start_out) |-> ##[1:12] (event_out.valid &&
      event_out.id == EV_START && !event_out.on))
    else $error("start off event missing");
  chk_stamp_order: assert property (
    event_out.valid && $past(event_out.valid) |->
      event_out.stamp >= $past(event_out.stamp))
    else $error("event stamp went back");
endmodule : stage_chk

bind phase_overcurrent_stage stage_chk #(.CYCLE_CLKS_P(CYCLE_CLKS_P)) chk_i (
  .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .psel_in(psel_in),
  .penable_in(penable_in), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .ext_block_in(ext_block_in),
  .start_out(start_out), .trip_out(trip_out), .blocked_out(blocked_out),
  .phase_start_out(phase_start_out), .event_out(event_out));

// file: verification/tb_top.sv
// Self-checking bench of the phase overcurrent stage.
`timescale 1ns/1ps
module tb_top;
  import overcurrent_pkg::*;
  localparam int CC = 20;
  logic ref_clk_in, reset_n_in, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] level, harm, harm2, fund;
  logic [2:0] phase, grp, ph_start, ph_trip;
  logic blk, ext_blk, start, trip, blocked, e;
  phase_current_type cur;
  event_type evt;
  int fail_count, check_count;

  stage_source src (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .level_in(level), .phase_in(phase), .block_in(blk), .harm_in(harm),
    .current_out(cur), .harm2_out(harm2), .fund_out(fund),
    .group_out(grp), .ext_block_out(ext_blk));
  phase_overcurrent_stage #(.CYCLE_CLKS_P(CC)) uut (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .current_in(cur), .harm2_in(harm2),
    .fund_in(fund), .setting_group_in(grp), .ext_block_in(ext_blk),
    .start_out(start), .trip_out(trip), .blocked_out(blocked),
    .phase_start_out(ph_start), .phase_trip_out(ph_trip), .event_out(evt));

  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic check(input string n, input logic [31:0] x, y);
    check_count++;
    if (y !== x) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, x, y);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    // An idle cycle between transfers keeps each strobe to one change.
    @(posedge ref_clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
  endtask : apb

  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    check(n, x, r);
  endtask : rd

  task automatic ticks(input int k);
    repeat (k * CC) @(posedge ref_clk_in);
  endtask : ticks

  task automatic lv(input logic [2:0] x);
    check("levels", {29'h0, x}, {29'h0, start, trip, blocked});
  endtask : lv

  task automatic reccount(input logic [3:0] x);
    apb(1'b0, OFF_STATUS, 32'h0);
    check("record count", {28'h0, x}, {28'h0, r[12:9]});
  endtask : reccount

  initial begin
    reset_n_in = 1'b0;
    {psel, penable, pwrite, blk, paddr, pwdata} = '0;
    {level, phase, harm} = '0;
    repeat (16) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    @(posedge ref_clk_in);
    rd("ctrl", OFF_CTRL, 32'h0);
    rd("harm limit", OFF_HARM, 32'h1);
    rd("pickup", OFF_PICKUP, 32'hF0);
    rd("evmask", OFF_EVMASK, 32'h01FF01FF);
    apb(1'b0, 8'h40, 32'h0);
    check("slverr", 32'h1, {31'h0, e});
    apb(1'b1, OFF_OPDLY, 32'hA);
    level <= 16'h00F1;
    phase <= 3'b001;
    ticks(3);
    lv(3'b100);
    check("phase start", 32'h1, {29'h0, ph_start});
    ticks(11);
    lv(3'b110);
    check("phase trip", 32'h1, {29'h0, ph_trip});
    reccount(4'h2);
    rd("record info", OFF_REC_INFO, 32'h33000000);
    rd("start count", OFF_CNT_START, 32'h1);
    rd("trip count", OFF_CNT_TRIP, 32'h1);
    level <= 16'h00E9;
    ticks(3);
    lv(3'b110);
    level <= 16'h00E8;
    ticks(3);
    lv(3'b000);
    reccount(4'h2);
    apb(1'b1, OFF_CTRL, 32'h1C);
    rd("start count", OFF_CNT_START, 32'h0);
    rd("trip count", OFF_CNT_TRIP, 32'h0);
    level <= 16'h0100;
    ticks(3);
    lv(3'b100);
    blk <= 1'b1;
    ticks(3);
    check("late block", 32'h0, {30'h0, start, trip});
    level <= 16'h0000;
    ticks(3);
    level <= 16'h0100;
    ticks(3);
    lv(3'b001);
    blk <= 1'b0;
    ticks(3);
    lv(3'b001);
    level <= 16'h0000;
    ticks(3);
    lv(3'b000);
    // Pick-up outlasts the late block, so BLOCKED followed it once already.
    rd("block count", OFF_CNT_BLOCK, 32'h2);
    apb(1'b1, OFF_CTRL, 32'h1);
    harm <= 16'h0064;
    level <= 16'h0100;
    ticks(3);
    lv(3'b001);
    level <= 16'h0000;
    harm <= 16'h0000;
    ticks(3);
    for (int i = 0; i < 11; i++) begin
      level <= 16'h0100;
      ticks(3);
      level <= 16'h0000;
      ticks(3);
    end
    reccount(4'hC);
    apb(1'b1, OFF_REC_SEL, 32'hB);
    apb(1'b0, OFF_REC_INFO, 32'h0);
    check("oldest kind", 32'h3, {30'h0, r[24:23]});
    apb(1'b1, OFF_REC_SEL, 32'hC);
    rd("beyond count", OFF_REC_INFO, 32'h0);
    reset_n_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    @(posedge ref_clk_in);
    reccount(4'h0);
    rd("start count", OFF_CNT_START, 32'h0);
    print_verdict();
  end
endmodule : tb_top
